/* File: flash_self_program_pkg.sv */
package flash_self_program_pkg;

    // ****************
    // Register map
    // ****************
    localparam logic [7:0] CSR_OFF       = 8'h00;
    localparam logic [7:0] STAT_OFF      = 8'h04;
    localparam logic [5:0] CSR_RESET     = 6'h00;
    localparam int         SIG_POS       = 5;
    localparam int         CLR_POS       = 4;
    localparam int         FUSE_POS      = 3;
    localparam int         WRT_POS       = 2;
    localparam int         ERS_POS       = 1;
    localparam int         EN_POS        = 0;

    // ****************
    // Pointer layout
    // ****************
    localparam int         PAGE_WORDS    = 32;
    localparam int         WORD_BITS     = 5;
    localparam int         WORD_LSB      = 1;
    localparam int         PAGE_LSB      = 6;
    localparam int         PAGE_BITS     = 10;
    localparam logic [15:0] PTR_FLB      = 16'h0000;
    localparam logic [15:0] PTR_LOCK     = 16'h0001;
    localparam logic [15:0] PTR_FEB      = 16'h0002;
    localparam logic [15:0] PTR_FHB      = 16'h0003;
    localparam int         SIG_ENTRIES   = 4;

    // ****************
    // Timing
    // ****************
    localparam logic [2:0] LOAD_WIN      = 3'd3;
    localparam logic [2:0] STORE_WIN     = 3'd4;
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         OP_MIN_NS     = 3700000;
    localparam int         OP_MAX_NS     = 4500000;
    localparam int         OP_CYCLES     = (OP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         OP_CNT_BITS   = 19;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} op_state_t;

    typedef struct packed {
        logic        load;
        logic        store;
        logic [15:0] pointer;
        logic [15:0] store_data_pair;
    } cpu_req_t;

    typedef struct packed {
        logic [7:0] fuse_low_byte_prog;
        logic [7:0] fuse_high_byte_prog;
        logic [7:0] fuse_extended_byte_prog;
        logic [1:0] lock_prog;
    } fuse_state_t;

endpackage

/* File: page_buffer_ram.sv */
`timescale 1ns/1ps
module page_buffer_ram (
    input  wire logic                                             clk,
    input  wire logic                                             rst_n,
    input  wire logic                                             clear,
    input  wire logic                                             wr_en,
    input  wire logic [flash_self_program_pkg::WORD_BITS-1:0]     wr_addr,
    input  wire logic [15:0]                                      wr_data,
    input  wire logic [flash_self_program_pkg::WORD_BITS-1:0]     rd_addr,
    output logic      [15:0]                                      rd_data
);
    import flash_self_program_pkg::*;

    logic [15:0]           mem [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] valid_r;

    // Valid mask gives a one-cycle clear without touching the array
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_r <= '0;
        end else begin
            if (clear) begin
                valid_r <= '0;
            end
            if (wr_en) begin
                valid_r[wr_addr] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Unloaded words read as erased flash
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'hffff;
        end else begin
            rd_data <= valid_r[rd_addr] ? mem[rd_addr] : 16'hffff;
        end
    end
endmodule // page_buffer_ram

/* File: flash_self_program_control.sv */
// What this block does
// RL1: Fuse and lock bits read back inverted: programmed gives zero, unprogrammed one.
// RL2: Load with pointer 0x0001 inside three-cycle read window returns lock bits.
// RL3: Read select and enable clear on read, or after the window expires.
// RL4: After read bits clear, loads fetch ordinary flash contents again.
// RL5: Pointers 0x0000, 0x0003, 0x0002 return low, high, extended fuse bytes.
// RL6: Load within three cycles of signature arming returns indexed table entry.
// RL7: Signature select and enable clear three cycles after being set.
// RL8: Control register bits 7..6 always read zero.
// RL9: Writing buffer clear bit together with enable discards everything loaded into the page buffer.
// RL10: Fuse read select with enable makes next load return fuse or lock.
// RL11: Page write bit with enable: next store writes buffer to pointer page.
// RL12: Page write bit clears on completion or timeout; CPU halted meanwhile.
// RL13: Page erase bit with enable: next store erases the pointer page.
// RL14: Page erase bit clears on completion or timeout; CPU halted meanwhile.
// RL15: Enable bit arms the store for four cycles, special with a select.
// RL16: Plain enable: next store puts data pair into the addressed buffer word.
// RL17: Enable clears after store or timeout, but holds through erase and write.
// RL18: Erase and write last between 3.7 ms and 4.5 ms each.
// RL19: A flash operation in progress completes despite a system reset.
// RL20: EEPROM write in progress blocks flash programming and fuse reads.
// RL21: Stores do nothing unless the self-program enable fuse is programmed.
// RL22: Page buffer clears after page write, clear bit and system reset.
// RL23: Select bits written without enable trigger nothing.
// RL24: Windows count system clocks from the cycle the register write lands.
`timescale 1ns/1ps
module flash_self_program_control #(
    parameter int OP_LEN = flash_self_program_pkg::OP_CYCLES
) (
    input  wire logic                                                 hclk,
    input  wire logic                                                 hresetn,
    input  wire logic                                                 por_n,
    input  wire logic                                                 hsel,
    input  wire logic [31:0]                                          haddr,
    input  wire logic [1:0]                                           htrans,
    input  wire logic                                                 hwrite,
    input  wire logic [2:0]                                           hsize,
    input  wire logic [31:0]                                          hwdata,
    input  wire logic                                                 hready,
    output logic                                                      hreadyout,
    output logic                                                      hresp,
    output logic      [31:0]                                          hrdata,
    input  wire flash_self_program_pkg::cpu_req_t                     cpu_req,
    input  wire flash_self_program_pkg::fuse_state_t                  fuses,
    input  wire logic [flash_self_program_pkg::SIG_ENTRIES-1:0][7:0]  sig_table,
    input  wire logic                                                 eeprom_busy,
    output logic                                                      load_special,
    output logic      [7:0]                                           load_data,
    output logic                                                      cpu_halt,
    output logic                                                      flash_erase,
    output logic                                                      flash_write,
    output logic      [flash_self_program_pkg::PAGE_BITS-1:0]         flash_page,
    input  wire logic [flash_self_program_pkg::WORD_BITS-1:0]         flash_rd_addr,
    output logic      [15:0]                                          flash_rd_data
);
    import flash_self_program_pkg::*;

    localparam logic [OP_CNT_BITS-1:0] OP_LAST = OP_CNT_BITS'(OP_LEN - 1);

    // ****************
    // Bus slave
    // ****************
    logic        dwr_r;
    logic [7:0]  daddr_r;
    logic [5:0]  csr_r;
    logic [5:0]  csr_nxt;
    logic [2:0]  win_r;
    logic [2:0]  win_nxt;
    op_state_t   state_r;
    logic [OP_CNT_BITS-1:0] cnt_r;

    wire         aphase   = hsel & htrans[1] & hready;
    wire         busy     = (state_r != ST_IDLE);
    wire         self_ok  = fuses.fuse_extended_byte_prog[0];                        // [RL21]
    wire [7:0]   csr_rd   = {2'b00, csr_r[5:1], csr_r[EN_POS] | busy};               // [RL8]
    wire [7:0]   stat_rd  = {3'b000, win_r, self_ok, busy};
    wire [31:0]  rd_mux   = (haddr[7:0] == CSR_OFF)  ? {24'h000000, csr_rd}  :
                            (haddr[7:0] == STAT_OFF) ? {24'h000000, stat_rd} : 32'h00000000;
    wire         wr_csr   = dwr_r & (daddr_r == CSR_OFF) & ~eeprom_busy;             // [RL20]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dwr_r     <= 1'b0;
            daddr_r   <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            dwr_r     <= aphase & hwrite;
            daddr_r   <= haddr[7:0];
            hrdata    <= (aphase & ~hwrite) ? rd_mux : 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ****************
    // Command decode
    // ****************
    wire         armed     = csr_r[EN_POS] & ~busy;
    wire         load_arm  = armed & (csr_r[FUSE_POS] | csr_r[SIG_POS]);
    wire         fuse_arm  = armed & csr_r[FUSE_POS] & ~eeprom_busy;                 // [RL20]
    wire         store_arm = armed & ~csr_r[FUSE_POS] & ~csr_r[SIG_POS];
    wire         store_go  = store_arm & cpu_req.store & self_ok & ~eeprom_busy;     // [RL21] [RL20]
    wire         erase_go  = store_go & csr_r[ERS_POS];                              // [RL13]
    wire         write_go  = store_go & ~csr_r[ERS_POS] & csr_r[WRT_POS];            // [RL11]
    wire         word_go   = store_go & ~csr_r[ERS_POS] & ~csr_r[WRT_POS];           // [RL16]
    wire         op_done   = busy & (cnt_r == '0);
    wire         arm_load  = hwdata[FUSE_POS] | hwdata[SIG_POS];
    wire         clr_cmd   = wr_csr & ~busy & hwdata[EN_POS] & hwdata[CLR_POS];      // [RL9]
    wire         buf_clr   = clr_cmd | (op_done & (state_r == ST_WRITE));            // [RL22]

    always_comb begin
        csr_nxt = csr_r;
        win_nxt = win_r;
        if (busy) begin
            if (op_done) begin
                csr_nxt = CSR_RESET;                                                 // [RL12] [RL14]
            end
        end else if (wr_csr) begin
            if (!hwdata[EN_POS] || hwdata[CLR_POS]) begin
                csr_nxt = CSR_RESET;                                                 // [RL23]
                win_nxt = 3'd0;
            end else begin
                csr_nxt = hwdata[5:0];                                               // [RL15] [RL24]
                win_nxt = arm_load ? LOAD_WIN : STORE_WIN;                           // [RL10] [RL6]
            end
        end else if (csr_r[EN_POS]) begin
            if (erase_go || write_go) begin
                win_nxt = 3'd0;                                                      // [RL17]
            end else if (word_go || (fuse_arm && cpu_req.load)) begin
                csr_nxt = CSR_RESET;                                                 // [RL3] [RL17]
                win_nxt = 3'd0;
            end else if (win_r <= 3'd1) begin
                csr_nxt = CSR_RESET;                                                 // [RL3] [RL7] [RL17]
                win_nxt = 3'd0;
            end else begin
                win_nxt = win_r - 3'd1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csr_r <= CSR_RESET;
            win_r <= 3'd0;
        end else begin
            csr_r <= csr_nxt;
            win_r <= win_nxt;
        end
    end

    // ****************
    // Configuration reads
    // ****************
    wire [7:0] fuse_sel =
        (cpu_req.pointer == PTR_FLB)  ? ~fuses.fuse_low_byte_prog      :             // [RL5] [RL1]
        (cpu_req.pointer == PTR_FHB)  ? ~fuses.fuse_high_byte_prog     :
        (cpu_req.pointer == PTR_FEB)  ? ~fuses.fuse_extended_byte_prog :
        (cpu_req.pointer == PTR_LOCK) ? {6'h3f, ~fuses.lock_prog}      : 8'hff;      // [RL2]
    wire [7:0] sig_sel  = sig_table[cpu_req.pointer[1:0]];                           // [RL6]
    wire       spec_hit = cpu_req.load & (fuse_arm | (load_arm & csr_r[SIG_POS]));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_special <= 1'b0;
            load_data    <= 8'h00;
        end else begin
            load_special <= spec_hit;                                                // [RL4]
            load_data    <= !spec_hit ? 8'h00 : csr_r[FUSE_POS] ? fuse_sel : sig_sel;
        end
    end

    // ****************
    // Flash operation timer
    // ****************
    // Kept on power-on reset only so a system reset cannot cut an operation short
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            state_r     <= ST_IDLE;
            cnt_r       <= '0;
            cpu_halt    <= 1'b0;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_page  <= '0;
        end else begin
            flash_erase <= erase_go;
            flash_write <= write_go;
            unique case (state_r)
                ST_IDLE: begin
                    if (erase_go || write_go) begin
                        state_r    <= erase_go ? ST_ERASE : ST_WRITE;
                        cnt_r      <= OP_LAST;                                       // [RL18]
                        cpu_halt   <= 1'b1;                                          // [RL12] [RL14]
                        flash_page <= cpu_req.pointer[PAGE_LSB +: PAGE_BITS];
                    end
                end
                ST_ERASE, ST_WRITE: begin
                    if (op_done) begin
                        state_r  <= ST_IDLE;
                        cpu_halt <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;                                       // [RL19]
                    end
                end
            endcase
        end
    end

    // ****************
    // Page buffer
    // ****************
    page_buffer_ram u_buf (
        .clk     (hclk),
        .rst_n   (hresetn),
        .clear   (buf_clr),
        .wr_en   (word_go),
        .wr_addr (cpu_req.pointer[WORD_LSB +: WORD_BITS]),
        .wr_data (cpu_req.store_data_pair),
        .rd_addr (flash_rd_addr),
        .rd_data (flash_rd_data)
    );

    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_reserved_zero;
        dwr_r |-> csr_rd[7:6] == 2'b00 && stat_rd[7:5] == 3'b000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // [RL8]

    property p_lock_read;
        fuse_arm && cpu_req.load && cpu_req.pointer == PTR_LOCK
            |=> load_special && load_data == {6'h3f, ~$past(fuses.lock_prog)};
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock read wrong"); // [RL2]

    property p_fuse_low;
        fuse_arm && cpu_req.load && cpu_req.pointer == PTR_FLB
            |=> load_data == ~$past(fuses.fuse_low_byte_prog) ##1 !csr_r[FUSE_POS];
    endproperty
    a_fuse_low: assert property (p_fuse_low) else $error("low fuse read wrong"); // [RL5]

    property p_normal_load;
        cpu_req.load && !load_arm |=> !load_special;
    endproperty
    a_normal_load: assert property (p_normal_load) else $error("special load unarmed"); // [RL4]

    property p_sig_clear;
        $rose(csr_r[SIG_POS]) && !busy |-> csr_r[SIG_POS] [*3] ##1 !csr_r[SIG_POS];
    endproperty
    a_sig_clear: assert property (p_sig_clear) else $error("signature window length"); // [RL7]

    property p_store_timeout;
        $rose(csr_r[EN_POS]) && win_r == STORE_WIN && !cpu_req.store
            ##1 !cpu_req.store [*3] |=> csr_r == CSR_RESET;
    endproperty
    a_store_timeout: assert property (p_store_timeout) else $error("store window not closed"); // [RL17]

    property p_no_enable;
        wr_csr && !busy && !hwdata[EN_POS] |=> csr_r == CSR_RESET && !load_arm;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("command armed without enable"); // [RL23]

    property p_halt_op;
        erase_go || write_go |=> cpu_halt && csr_r[EN_POS] && flash_page == $past(cpu_req.pointer[15:6]);
    endproperty
    a_halt_op: assert property (p_halt_op) else $error("operation start wrong"); // [RL12]

    property p_halt_hold;
        $rose(cpu_halt) |-> cpu_halt [*2] ##0 csr_rd[EN_POS];
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt or enable dropped"); // [RL14]

    property p_eeprom_block;
        dwr_r && daddr_r == CSR_OFF && eeprom_busy |=> $stable(csr_r);
    endproperty
    a_eeprom_block: assert property (p_eeprom_block) else $error("write during eeprom"); // [RL20]

    // Independent halt length, so the timer does not grade itself
    logic [OP_CNT_BITS-1:0] halt_len_r;

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            halt_len_r <= '0;
        end else begin
            halt_len_r <= cpu_halt ? halt_len_r + 1'b1 : '0;
        end
    end

    property p_op_length;
        $fell(cpu_halt) |-> halt_len_r == OP_CNT_BITS'(OP_LEN);
    endproperty
    a_op_length: assert property (p_op_length) else $error("operation length wrong"); // [RL18]

    property p_erase_pulse;
        erase_go |=> flash_erase && !flash_write && busy;
    endproperty
    a_erase_pulse: assert property (p_erase_pulse) else $error("erase start wrong"); // [RL13]

    property p_write_pulse;
        write_go |=> flash_write && !flash_erase && busy;
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write start wrong"); // [RL11]

    property p_fuse_clear;
        fuse_arm && cpu_req.load |=> !csr_r[FUSE_POS] && !csr_r[EN_POS];
    endproperty
    a_fuse_clear: assert property (p_fuse_clear) else $error("read select kept"); // [RL3]

    property p_fuse_window;
        $rose(csr_r[FUSE_POS]) && !cpu_req.load ##1 !cpu_req.load [*2] |=> !csr_r[FUSE_POS];
    endproperty
    a_fuse_window: assert property (p_fuse_window) else $error("read window too long"); // [RL24]

    property p_buf_clear;
        clr_cmd && !word_go |=> u_buf.valid_r == '0;
    endproperty
    a_buf_clear: assert property (p_buf_clear) else $error("buffer not cleared"); // [RL9]

    property p_word_store;
        word_go |=> u_buf.valid_r[$past(cpu_req.pointer[WORD_LSB +: WORD_BITS])];
    endproperty
    a_word_store: assert property (p_word_store) else $error("buffer word not stored"); // [RL16]

    property p_sig_read;
        load_arm && csr_r[SIG_POS] && !csr_r[FUSE_POS] && cpu_req.load
            |=> load_special && load_data == $past(sig_table[cpu_req.pointer[1:0]]);
    endproperty
    a_sig_read: assert property (p_sig_read) else $error("signature read wrong"); // [RL6]

    property p_eeprom_store;
        eeprom_busy && cpu_req.store |=> !flash_erase && !flash_write;
    endproperty
    a_eeprom_store: assert property (p_eeprom_store) else $error("store during eeprom"); // [RL20]

    property p_fuse_gate;
        !fuses.fuse_extended_byte_prog[0] && cpu_req.store |=> !flash_erase && !flash_write;
    endproperty
    a_fuse_gate: assert property (p_fuse_gate) else $error("store without fuse"); // [RL21]

    c_lock_read:  cover property (fuse_arm && cpu_req.load && cpu_req.pointer == PTR_LOCK);
    c_sig_read:   cover property (load_arm && csr_r[SIG_POS] && cpu_req.load);
    c_word_store: cover property (word_go);
    c_page_write: cover property (write_go ##1 cpu_halt);
endmodule // flash_self_program_control

/* File: cpu_core_model.sv */
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic                               hclk,
    output flash_self_program_pkg::cpu_req_t        cpu_req
);
    import flash_self_program_pkg::*;

    // ****************
    // Instruction issue
    // ****************
    initial cpu_req = '0;

    // One load, issued at the next edge; the caller picks whether that falls inside the armed window
    task automatic load_at(input logic [15:0] ptr);
        cpu_req.pointer <= ptr;
        cpu_req.load    <= 1'b1;
        @(posedge hclk);
        cpu_req.load    <= 1'b0;
        // Released bus shows junk, not the last pointer
        cpu_req.pointer <= ~ptr;
    endtask

    task automatic store_at(input logic [15:0] ptr, input logic [15:0] dat);
        cpu_req.pointer         <= ptr;
        cpu_req.store_data_pair <= dat;
        cpu_req.store           <= 1'b1;
        @(posedge hclk);
        cpu_req.store           <= 1'b0;
        cpu_req.pointer         <= ~ptr;
        cpu_req.store_data_pair <= ~dat;
    endtask
endmodule // cpu_core_model

/* File: flash_self_program_control_bench.sv */
`timescale 1ns/1ps
module flash_self_program_control_bench;
    import flash_self_program_pkg::*;

    // ****************
    // Stimulus and wiring
    // ****************
    localparam int OPL = 8;
    logic                        hclk = 1'b0;
    logic                        hresetn = 1'b0;
    logic                        por_n = 1'b0;
    logic                        hsel = 1'b0;
    logic                        hwrite = 1'b0;
    logic                        eeprom_busy = 1'b0;
    logic [31:0]                 haddr = 32'h0;
    logic [31:0]                 hwdata = 32'h0;
    logic [1:0]                  htrans = 2'h0;
    logic [4:0]                  flash_rd_addr = 5'h0;
    fuse_state_t                 fuses = '{8'h5a, 8'hc3, 8'h01, 2'b01};
    logic [SIG_ENTRIES-1:0][7:0] sig_table = {8'h93, 8'h92, 8'h91, 8'h90};
    cpu_req_t                    cpu_req;
    wire logic                   hreadyout, hresp, load_special, cpu_halt, flash_erase, flash_write;
    wire logic [31:0]            hrdata;
    wire logic [7:0]             load_data;
    wire logic [9:0]             flash_page;
    wire logic [15:0]            flash_rd_data;
    int                          err_count = 0;
    int                          checks_done = 0;
    int                          halt_cnt = 0;
    logic [31:0]                 rd;
    logic [15:0]                 ptrs [4] = '{PTR_FLB, PTR_LOCK, PTR_FEB, PTR_FHB};
    // Programmed bits read back as zero, lock byte padded with ones
    logic [7:0]                  fexp [4] = '{~8'h5a, {6'h3f, ~2'b01}, ~8'h01, ~8'hc3};

    always #5 hclk = ~hclk;
    always @(posedge hclk) if (cpu_halt === 1'b1) halt_cnt <= halt_cnt + 1;

    flash_self_program_control #(.OP_LEN(OPL)) u_flash_self_program_control (
        .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_req(cpu_req), .fuses(fuses),
        .sig_table(sig_table), .eeprom_busy(eeprom_busy), .load_special(load_special),
        .load_data(load_data), .cpu_halt(cpu_halt), .flash_erase(flash_erase),
        .flash_write(flash_write), .flash_page(flash_page), .flash_rd_addr(flash_rd_addr),
        .flash_rd_data(flash_rd_data)
    );

    cpu_core_model u_cpu_core_model (.hclk(hclk), .cpu_req(cpu_req));

    // ****************
    // Bus and compare tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] d);
        ahb_xfer(1'b1, {24'h0, CSR_OFF}, d);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        ahb_xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Buffer port is registered: value lands one cycle after the address
    task automatic buf_chk(input logic [4:0] a, input logic [15:0] exp);
        flash_rd_addr <= a;
        repeat (2) @(posedge hclk);
        check({16'h0, flash_rd_data}, {16'h0, exp});
    endtask

    task automatic op_run(input logic [7:0] cmd, input logic [15:0] ptr, input logic [1:0] pulse);
        int h0;
        wr({24'h0, cmd});
        u_cpu_core_model.store_at(ptr, 16'hdead);
        h0 = halt_cnt;
        for (int i = 0; i < 4 && !(flash_erase | flash_write); i++) @(posedge hclk);
        check({30'h0, flash_erase, flash_write}, {30'h0, pulse});
        check({22'h0, flash_page}, {22'h0, ptr[15:6]});
        ahb_xfer(1'b0, {24'h0, CSR_OFF}, 32'h0);
        check(rd & 32'h1, 32'h1);
        // Only the erase is hit by a system reset, so the write still proves the buffer wipe
        if (pulse[1]) begin
            hresetn <= 1'b0;
            @(posedge hclk);
            check({31'h0, cpu_halt}, 32'h1);
            hresetn <= 1'b1;
        end
        for (int i = 0; i < 60 && cpu_halt === 1'b1; i++) @(posedge hclk);
        check({31'h0, (halt_cnt - h0 >= OPL) && (halt_cnt - h0 <= OPL + 2)}, 32'h1);
        rdchk({24'h0, CSR_OFF}, 32'h0);
    endtask

    task automatic stop_test;
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        stop_test;
    end

    // ****************
    // Test sequence
    // ****************
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        por_n   <= 1'b1;
        rdchk({24'h0, CSR_OFF}, 32'h0);
        rdchk(32'h0000_0008, 32'h0);
        wr(32'hc1);
        rdchk({24'h0, CSR_OFF}, 32'h1);
        check({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(32'h09);
            u_cpu_core_model.load_at(ptrs[i]);
            #1;
            check({31'h0, load_special}, 32'h1);
            check({24'h0, load_data}, {24'h0, fexp[i]});
            rdchk({24'h0, CSR_OFF}, 32'h0);
        end
        // Load one cycle past the window must fetch plain flash
        wr(32'h09);
        repeat (3) @(posedge hclk);
        u_cpu_core_model.load_at(PTR_LOCK);
        #1;
        check({31'h0, load_special}, 32'h0);
        wr(32'h08);
        u_cpu_core_model.load_at(PTR_LOCK);
        #1;
        check({31'h0, load_special}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(32'h21);
            u_cpu_core_model.load_at({14'h0, 2'(i)});
            #1;
            check({24'h0, load_data}, {24'h0, 8'h90 + 8'(i)});
            repeat (3) @(posedge hclk);
            rdchk({24'h0, CSR_OFF}, 32'h0);
        end
        wr(32'h01);
        u_cpu_core_model.store_at({10'h0, 5'd5, 1'b1}, 16'ha5a5);
        buf_chk(5'd5, 16'ha5a5);
        rdchk({24'h0, CSR_OFF}, 32'h0);
        wr(32'h11);
        buf_chk(5'd5, 16'hffff);
        wr(32'h01);
        repeat (4) @(posedge hclk);
        u_cpu_core_model.store_at({10'h0, 5'd6, 1'b0}, 16'h6666);
        buf_chk(5'd6, 16'hffff);
        eeprom_busy <= 1'b1;
        wr(32'h01);
        rdchk({24'h0, CSR_OFF}, 32'h0);
        eeprom_busy <= 1'b0;
        fuses.fuse_extended_byte_prog <= 8'h00;
        wr(32'h01);
        u_cpu_core_model.store_at({10'h0, 5'd7, 1'b0}, 16'h7777);
        buf_chk(5'd7, 16'hffff);
        fuses.fuse_extended_byte_prog <= 8'h01;
        op_run(8'h03, {10'h2a, 6'h00}, 2'b10);
        wr(32'h01);
        u_cpu_core_model.store_at({10'h2a, 5'd3, 1'b0}, 16'h1234);
        buf_chk(5'd3, 16'h1234);
        op_run(8'h05, {10'h2a, 6'h00}, 2'b01);
        buf_chk(5'd3, 16'hffff);
        rdchk({24'h0, STAT_OFF}, 32'h2);
        stop_test;
    end
endmodule // flash_self_program_control_bench
